// ==== hdl/lane_ctrl_pkg.sv ====
// package for common receive-lane control: register map, field layout, limits
// assumes a 32-bit classic wishbone register bus and a 132-bit lane word path
package lane_ctrl_pkg;
  localparam int          DATA_W            = 32;
  localparam int          ADDR_W            = 8;
  localparam int          LANE_W            = 132;
  localparam int          PAR_W             = 64;
  localparam int          FIFO_DEPTH        = 8;
  localparam int          NUM_LANES         = 4;
  localparam logic [7:0]  COMMON_CTRL_ADDR  = 8'h00;
  localparam logic [7:0]  ALIGN_STATUS_ADDR = 8'h04;
  localparam int          LOOPBACK_BIT      = 10;
  localparam int          SH_LIM_LO         = 6;
  localparam int          SH_LIM_W          = 4;
  localparam int          EMB_LIM_LO        = 3;
  localparam int          EMB_LIM_W         = 3;
  localparam int          DESCR_OFF_BIT     = 1;
  localparam int          BIT_ORDER_BIT     = 0;
  localparam logic        LOOPBACK_RST      = 1'b0;
  localparam logic [3:0]  SH_LIM_RST        = 4'hF;
  localparam logic [2:0]  EMB_LIM_RST       = 3'h7;
  localparam logic        DESCR_OFF_RST     = 1'b0;
  localparam logic        BIT_ORDER_MSB     = 1'b0;
  localparam logic [1:0]  SYNC_HDR_GOOD_A   = 2'h1;
  localparam logic [1:0]  SYNC_HDR_GOOD_B   = 2'h2;
  localparam int          LOCK_COUNT        = 64;
  localparam int          EMB_LOCK_COUNT    = 4;
  localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_WORD     = 32'h0000_0000;
endpackage

// ==== hdl/lane_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
// assumes one clock; synchronous active-low reset and clock enable from parent
`timescale 1ns/1ps
`default_nettype none
module lane_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers wrap by compare so depth need not be a power of two
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/rx_lane_common_control.sv ====
// common receive-lane control: one setting set, loopback mux, bit order,
// descrambler bypass, sync-header and extended-multiblock alignment
// assumes lane words already on CLOCK_I; wishbone master on the same clock
//
// Notes on behaviour
// - one control register drives every lane alike, no per-lane copies.
// - loopback bit 10 set selects the 132-bit transmit loopback word over gearbox data.
// - header alignment returns to hunt after bits 9:6 plus one consecutive bad headers.
// - multiblock alignment returns to hunt after bits 5:3 plus one consecutive errors.
// - descrambler-off bit 1 set passes received data unscrambled.
// - bit 0 is read-only build-time bit order, 0 lsb-first, 1 msb-first.
// - msb-first order reverses each deserialised parallel word on arrival.
// - build-time fields take their build value on reset.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module rx_lane_common_control
  import lane_ctrl_pkg::*;
#(
  parameter logic [3:0] SH_LIMIT_INIT  = lane_ctrl_pkg::SH_LIM_RST,
  parameter logic [2:0] EMB_LIMIT_INIT = lane_ctrl_pkg::EMB_LIM_RST,
  parameter logic       DESCR_OFF_INIT = lane_ctrl_pkg::DESCR_OFF_RST,
  parameter logic       MSB_FIRST      = lane_ctrl_pkg::BIT_ORDER_MSB
) (
  input  wire logic                                  CLOCK_I,
  input  wire logic                                  RST_N_I,
  input  wire logic                                  CE_I,
  input  wire logic                                  WB_CYC_I,
  input  wire logic                                  WB_STB_I,
  input  wire logic                                  WB_WE_I,
  input  wire logic [lane_ctrl_pkg::ADDR_W-1:0]      WB_ADR_I,
  input  wire logic [3:0]                            WB_SEL_I,
  input  wire logic [lane_ctrl_pkg::DATA_W-1:0]      WB_DAT_I,
  output logic      [lane_ctrl_pkg::DATA_W-1:0]      WB_DAT_O,
  output logic                                       WB_ACK_O,
  input  wire logic [lane_ctrl_pkg::PAR_W-1:0]       DESER_WORD_I,
  input  wire logic                                  DESER_VALID_I,
  input  wire logic [lane_ctrl_pkg::LANE_W-1:0]      GEARBOX_WORD_I,
  input  wire logic                                  GEARBOX_VALID_I,
  input  wire logic [lane_ctrl_pkg::LANE_W-1:0]      LOOPBACK_WORD_I,
  input  wire logic                                  LOOPBACK_VALID_I,
  output logic                                       IN_READY_O,
  output logic      [lane_ctrl_pkg::PAR_W-1:0]       ALIGNED_WORD_O,
  output logic      [lane_ctrl_pkg::LANE_W-1:0]      RX_WORD_O,
  output logic                                       RX_VALID_O,
  input  wire logic                                  RX_READY_I,
  output logic                                       HEADER_LOCK_O,
  output logic                                       EMB_LOCK_O,
  output logic                                       DESCR_OFF_O
);
  import lane_ctrl_pkg::*;

  typedef enum logic [1:0] {HEADER_HUNT, HEADER_LOCKED} hdr_state_t;
  typedef enum logic [1:0] {EMB_HUNT, EMB_LOCKED} emb_state_t;

  logic              loopback_reg;
  logic [3:0]        sh_limit_reg;
  logic [2:0]        emb_limit_reg;
  logic              descr_off_reg;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] status_word;
  logic              wb_hit;

  // common register view shared by every lane
  always_comb begin
    ctrl_word = ZERO_WORD;
    ctrl_word[LOOPBACK_BIT] = loopback_reg;
    ctrl_word[SH_LIM_LO +: SH_LIM_W] = sh_limit_reg;
    ctrl_word[EMB_LIM_LO +: EMB_LIM_W] = emb_limit_reg;
    ctrl_word[DESCR_OFF_BIT] = descr_off_reg;
    ctrl_word[BIT_ORDER_BIT] = MSB_FIRST;
  end

  assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= ZERO_WORD;
    end else if (CE_I) begin
      WB_ACK_O <= wb_hit;
      if (wb_hit && !WB_WE_I) begin
        case (WB_ADR_I)
          COMMON_CTRL_ADDR:  WB_DAT_O <= ctrl_word;
          ALIGN_STATUS_ADDR: WB_DAT_O <= status_word;
          default:           WB_DAT_O <= UNMAPPED_WORD;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      loopback_reg  <= LOOPBACK_RST;
      sh_limit_reg  <= SH_LIMIT_INIT;
      emb_limit_reg <= EMB_LIMIT_INIT;
      descr_off_reg <= DESCR_OFF_INIT;
    end else if (CE_I && wb_hit && WB_WE_I && WB_ADR_I == COMMON_CTRL_ADDR) begin
      if (WB_SEL_I[1]) begin
        loopback_reg <= WB_DAT_I[LOOPBACK_BIT];
        sh_limit_reg[3:2] <= WB_DAT_I[9:8];
      end
      if (WB_SEL_I[0]) begin
        sh_limit_reg[1:0] <= WB_DAT_I[7:6];
        emb_limit_reg <= WB_DAT_I[EMB_LIM_LO +: EMB_LIM_W];
        descr_off_reg <= WB_DAT_I[DESCR_OFF_BIT];
      end
    end
  end

  // word aligner: deserialiser input mirrored when msb-first
  logic [PAR_W-1:0] rev_word;
  genvar gi;
  generate
    for (gi = 0; gi < PAR_W; gi++) begin : g_rev
      assign rev_word[gi] = MSB_FIRST ? DESER_WORD_I[PAR_W-1-gi] : DESER_WORD_I[gi];
    end
  endgenerate

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ALIGNED_WORD_O <= '0;
    end else if (CE_I && DESER_VALID_I) begin
      ALIGNED_WORD_O <= rev_word;
    end
  end

  // source mux feeding the fifo
  localparam int OCC_W = $clog2(FIFO_DEPTH) + 1;
  logic [LANE_W-1:0] src_word;
  logic              src_valid;
  logic              src_push;
  logic [OCC_W-1:0]  occ_reg;
  logic [OCC_W-1:0]  occ_next;
  logic              fifo_in_ready;
  logic [LANE_W-1:0] fifo_word;
  logic              fifo_valid;
  logic              fifo_take;

  always_comb begin
    if (loopback_reg) begin
      src_word  = LOOPBACK_WORD_I;
      src_valid = LOOPBACK_VALID_I;
    end else begin
      src_word  = GEARBOX_WORD_I;
      src_valid = GEARBOX_VALID_I;
    end
  end

  lane_fifo #(
    .WIDTH (LANE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLOCK_I),
    .rst_n_i     (RST_N_I),
    .ce_i        (CE_I),
    .in_data_i   (src_word),
    .in_valid_i  (src_push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_word),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_take)
  );

  // output stage register; stalls back into the fifo
  assign fifo_take = fifo_valid && (!RX_VALID_O || RX_READY_I);

  // shadow occupancy so the registered ready matches the fifo each cycle
  assign src_push = src_valid && IN_READY_O;
  always_comb begin
    occ_next = occ_reg;
    if (src_push && fifo_in_ready && !fifo_take) begin
      occ_next = occ_reg + 1'b1;
    end else if (fifo_take && !(src_push && fifo_in_ready)) begin
      occ_next = occ_reg - 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      IN_READY_O <= 1'b0;
      occ_reg    <= '0;
    end else if (CE_I) begin
      occ_reg    <= occ_next;
      IN_READY_O <= (occ_next != OCC_W'(FIFO_DEPTH));
    end
  end

  // descrambler: self-synchronous x^58+x^39+1 over the payload bits
  localparam int PAY_W = LANE_W - 4;
  logic [57:0]      scr_state_reg;
  logic [PAY_W-1:0] descr_word;
  logic [PAY_W+57:0] descr_chain;
  assign descr_chain = {fifo_word[PAY_W-1:0], scr_state_reg};
  generate
    for (gi = 0; gi < PAY_W; gi++) begin : g_descr
      assign descr_word[gi] = descr_chain[gi+58] ^ descr_chain[gi+19] ^ descr_chain[gi];
    end
  endgenerate

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      scr_state_reg <= '0;
    end else if (CE_I && fifo_take) begin
      scr_state_reg <= fifo_word[PAY_W-1 -: 58];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      RX_WORD_O  <= '0;
      RX_VALID_O <= 1'b0;
    end else if (CE_I) begin
      if (fifo_take) begin
        RX_VALID_O <= 1'b1;
        RX_WORD_O  <= descr_off_reg ? fifo_word
                                    : {fifo_word[LANE_W-1:PAY_W], descr_word};
      end else if (RX_READY_I) begin
        RX_VALID_O <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      DESCR_OFF_O <= DESCR_OFF_INIT;
    end else if (CE_I) begin
      DESCR_OFF_O <= descr_off_reg;
    end
  end

  // alignment on the sync header held in the top two bits
  hdr_state_t hdr_state_reg;
  emb_state_t emb_state_reg;
  logic [6:0] good_cnt_reg;
  logic [3:0] sh_err_reg;
  logic [2:0] emb_err_reg;
  logic [2:0] emb_good_reg;
  logic [1:0] sync_hdr;
  logic       hdr_ok;
  logic       emb_ok;

  assign sync_hdr = fifo_word[LANE_W-1 -: 2];
  assign hdr_ok   = (sync_hdr == SYNC_HDR_GOOD_A) || (sync_hdr == SYNC_HDR_GOOD_B);
  // extended-multiblock marker carried in the next header bits
  assign emb_ok   = fifo_word[LANE_W-3] ^ fifo_word[LANE_W-4];

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      hdr_state_reg <= HEADER_HUNT;
      good_cnt_reg  <= '0;
      sh_err_reg    <= '0;
    end else if (CE_I && fifo_take) begin
      case (hdr_state_reg)
        HEADER_HUNT: begin
          sh_err_reg <= '0;
          if (!hdr_ok) begin
            good_cnt_reg <= '0;
          end else if (good_cnt_reg == 7'(LOCK_COUNT - 1)) begin
            hdr_state_reg <= HEADER_LOCKED;
            good_cnt_reg  <= '0;
          end else begin
            good_cnt_reg <= good_cnt_reg + 1'b1;
          end
        end
        HEADER_LOCKED: begin
          if (hdr_ok) begin
            sh_err_reg <= '0;
          end else if (sh_err_reg == sh_limit_reg) begin
            hdr_state_reg <= HEADER_HUNT;
            sh_err_reg    <= '0;
          end else begin
            sh_err_reg <= sh_err_reg + 1'b1;
          end
        end
        default: hdr_state_reg <= HEADER_HUNT;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      emb_state_reg <= EMB_HUNT;
      emb_err_reg   <= '0;
      emb_good_reg  <= '0;
    end else if (CE_I && fifo_take) begin
      case (emb_state_reg)
        EMB_HUNT: begin
          emb_err_reg <= '0;
          if (hdr_state_reg != HEADER_LOCKED || !emb_ok) begin
            emb_good_reg <= '0;
          end else if (emb_good_reg == 3'(EMB_LOCK_COUNT - 1)) begin
            emb_state_reg <= EMB_LOCKED;
            emb_good_reg  <= '0;
          end else begin
            emb_good_reg <= emb_good_reg + 1'b1;
          end
        end
        EMB_LOCKED: begin
          if (hdr_state_reg != HEADER_LOCKED) begin
            emb_state_reg <= EMB_HUNT;
          end else if (emb_ok) begin
            emb_err_reg <= '0;
          end else if (emb_err_reg == emb_limit_reg) begin
            emb_state_reg <= EMB_HUNT;
            emb_err_reg   <= '0;
          end else begin
            emb_err_reg <= emb_err_reg + 1'b1;
          end
        end
        default: emb_state_reg <= EMB_HUNT;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      HEADER_LOCK_O <= 1'b0;
      EMB_LOCK_O    <= 1'b0;
    end else if (CE_I) begin
      HEADER_LOCK_O <= (hdr_state_reg == HEADER_LOCKED);
      EMB_LOCK_O    <= (emb_state_reg == EMB_LOCKED);
    end
  end

  // one status view for all lanes
  always_comb begin
    status_word = ZERO_WORD;
    status_word[0] = (hdr_state_reg == HEADER_LOCKED);
    status_word[1] = (emb_state_reg == EMB_LOCKED);
    status_word[7:4] = sh_err_reg;
    status_word[10:8] = emb_err_reg;
  end
endmodule
`default_nettype wire

// ==== verif/rx_lane_common_control_checker.sv ====
// checker: bus, bit order, reset, stall and bypass relations at the top ports
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module rx_lane_common_control_checker
  import lane_ctrl_pkg::*;
#(
  parameter logic MSB_FIRST = 1'b0
) (
  input wire logic                          CLOCK_I,
  input wire logic                          RST_N_I,
  input wire logic                          CE_I,
  input wire logic                          WB_CYC_I,
  input wire logic                          WB_STB_I,
  input wire logic                          WB_WE_I,
  input wire logic [lane_ctrl_pkg::ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0]                    WB_SEL_I,
  input wire logic [lane_ctrl_pkg::DATA_W-1:0] WB_DAT_I,
  input wire logic [lane_ctrl_pkg::DATA_W-1:0] WB_DAT_O,
  input wire logic                          WB_ACK_O,
  input wire logic [lane_ctrl_pkg::PAR_W-1:0]  DESER_WORD_I,
  input wire logic                          DESER_VALID_I,
  input wire logic [lane_ctrl_pkg::PAR_W-1:0]  ALIGNED_WORD_O,
  input wire logic [lane_ctrl_pkg::LANE_W-1:0] RX_WORD_O,
  input wire logic                          RX_VALID_O,
  input wire logic                          RX_READY_I,
  input wire logic                          DESCR_OFF_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic rd = WB_ACK_O && !WB_WE_I;
  function automatic logic [63:0] rv(input logic [63:0] d);
    rv = MSB_FIRST ? {<<{d}} : d;
  endfunction
  property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O && CE_I |=> WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_once; WB_ACK_O && CE_I |=> !WB_ACK_O; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_rsv; rd |-> WB_DAT_O[31:11] == '0 && !WB_DAT_O[2]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_bit0; rd && WB_ADR_I == COMMON_CTRL_ADDR |-> WB_DAT_O[0] == MSB_FIRST; endproperty
  a_bit0: assert property (p_bit0) else $error("bit order wrong");
  property p_rev; DESER_VALID_I && CE_I |=> ALIGNED_WORD_O == rv($past(DESER_WORD_I)); endproperty
  a_rev: assert property (p_rev) else $error("aligned word wrong");
  property p_rst; $rose(RST_N_I) |-> !WB_ACK_O && !RX_VALID_O && !DESCR_OFF_O; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_stall;
    RX_VALID_O && !RX_READY_I && CE_I |=> RX_VALID_O && $stable(RX_WORD_O);
  endproperty
  a_stall: assert property (p_stall) else $error("word dropped in stall");
  property p_descr;
    WB_ACK_O && WB_WE_I && WB_ADR_I == COMMON_CTRL_ADDR && WB_SEL_I[0] && WB_DAT_I[1]
      |-> ##[1:2] DESCR_OFF_O;
  endproperty
  a_descr: assert property (p_descr) else $error("bypass not set");
endmodule
bind rx_lane_common_control rx_lane_common_control_checker #(.MSB_FIRST(MSB_FIRST)) u_chk (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .DESER_WORD_I(DESER_WORD_I), .DESER_VALID_I(DESER_VALID_I),
  .ALIGNED_WORD_O(ALIGNED_WORD_O), .RX_WORD_O(RX_WORD_O), .RX_VALID_O(RX_VALID_O),
  .RX_READY_I(RX_READY_I), .DESCR_OFF_O(DESCR_OFF_O));
`default_nettype wire

// ==== verif/lane_source_model.sv ====
// converter-side lane source: numbered words with a chosen sync header
// assumes ready_i is the block's input ready; holds a word until taken
`timescale 1ns/1ps
`default_nettype none
module lane_source_model
  import lane_ctrl_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              ready_i,
  input  wire logic              send_i,
  input  wire logic [1:0]        hdr_i,
  output logic      [LANE_W-1:0] word_o,
  output logic                   valid_o
);
  logic [15:0] seq_reg = 16'h0;
  wire logic [15:0] seq_next = seq_reg + {15'h0, valid_o};
  initial valid_o = 1'b0;
  initial word_o = '0;
  // idle word toggles so a stale word is never mistaken for fresh data
  always @(posedge clk_i) begin
    if (!valid_o || ready_i) begin
      seq_reg <= seq_next;
      valid_o <= send_i;
      word_o  <= send_i ? {hdr_i, 114'h0, seq_next} : ~word_o;
    end
  end
endmodule
`default_nettype wire

// ==== verif/rx_lane_common_control_test.sv ====
// bench: register, bit order, fifo, lock and loopback sequences
// assumes the lane source model on the gearbox side, ce held high
`timescale 1ns/1ps
`default_nettype none
module rx_lane_common_control_test;
  import lane_ctrl_pkg::*;
  localparam logic MSB = 1'b1;
  logic         clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, dv = 0, lbv = 0;
  logic         rdy = 1, send = 0, gv, ack, in_rdy, rxv, hlock, descr;
  logic [1:0]   hdr = 2'h1;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  dwr = 32'h0, q, dat_o;
  logic [63:0]  dw = 64'h0, al;
  logic [131:0] lb = '0, gw, rxw;
  logic [131:0] got[$];
  int           n_fail = 0, num_checks = 0, base;
  always #25 clk = ~clk;
  rx_lane_common_control #(.MSB_FIRST(MSB)) dut (
    .CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dwr), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .DESER_WORD_I(dw), .DESER_VALID_I(dv), .GEARBOX_WORD_I(gw),
    .GEARBOX_VALID_I(gv), .LOOPBACK_WORD_I(lb), .LOOPBACK_VALID_I(lbv),
    .IN_READY_O(in_rdy), .ALIGNED_WORD_O(al), .RX_WORD_O(rxw), .RX_VALID_O(rxv),
    .RX_READY_I(rdy), .HEADER_LOCK_O(hlock), .EMB_LOCK_O(), .DESCR_OFF_O(descr));
  lane_source_model src (.clk_i(clk), .ready_i(in_rdy), .send_i(send), .hdr_i(hdr),
    .word_o(gw), .valid_o(gv));
  task automatic chk(input string nm, input logic [131:0] e, input logic [131:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dwr <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      print_verdict();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic drain(input int c);
    got.delete();
    repeat (c) begin
      @(posedge clk);
      if (rxv === 1'b1 && rdy === 1'b1) got.push_back(rxw);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // generous span, the sequence needs well under a thousand cycles
  initial begin
    #(50 * 3000);
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'h0, 8'h00, 32'h0);
    chk("ctrl_reset", 32'h3F9, q);
    wb(1'h1, 8'h00, 32'hFFFF_FFFF);
    wb(1'h0, 8'h00, 32'h0);
    chk("ctrl_reserved", 32'h7FB, q);
    wb(1'h0, 8'h08, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'h1, 8'h00, 32'h0BA);
    wb(1'h0, 8'h00, 32'h0);
    chk("ctrl_rw", 32'h0BB, q);
    chk("descr_off", 1'h1, descr);
    dw <= 64'h0123_4567_89AB_CDEF;
    dv <= 1'b1;
    @(posedge clk);
    dv <= 1'b0;
    @(posedge clk);
    chk("aligned", 64'({<<{dw}}), al);
    rdy  <= 1'b0;
    send <= 1'b1;
    base = int'(src.seq_reg);
    repeat (20) @(posedge clk);
    send <= 1'b0;
    chk("in_ready_full", 1'h0, in_rdy);
    rdy <= 1'b1;
    drain(40);
    chk("count", src.seq_reg - 16'(base), got.size());
    foreach (got[k]) chk("rx_word", {2'h1, 114'h0, 16'(base + k)}, got[k]);
    send <= 1'b1;
    repeat (90) @(posedge clk);
    chk("hdr_lock", 1'h1, hlock);
    wb(1'h0, 8'h04, 32'h0);
    chk("status_lock", 1'h1, q[0]);
    hdr <= 2'h0;
    repeat (2) @(posedge clk);
    hdr <= 2'h1;
    repeat (10) @(posedge clk);
    chk("lock_two_bad", 1'h1, hlock);
    hdr <= 2'h3;
    repeat (3) @(posedge clk);
    hdr <= 2'h1;
    repeat (10) @(posedge clk);
    chk("lock_three_bad", 1'h0, hlock);
    send <= 1'b0;
    repeat (15) @(posedge clk);
    wb(1'h1, 8'h00, 32'h4BA);
    lb   <= {2'h2, 130'h1_2345};
    lbv  <= 1'b1;
    send <= 1'b1;
    @(posedge clk);
    lbv <= 1'b0;
    drain(20);
    chk("lb_count", 1, got.size());
    chk("lb_word", lb, got[0]);
    send <= 1'b0;
    print_verdict();
  end
endmodule
`default_nettype wire
